// File: dbd_pkg.sv
package dbd_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 25;

    // Register byte offsets
    localparam logic [7:0] OFS_BLANKING_SELECT = 8'h00;
    localparam logic [7:0] OFS_SLOPE_RAMP_CONTROL = 8'h04;
    localparam logic [7:0] OFS_DRIVE_DEAD_TIME = 8'h08;
    localparam logic [7:0] OFS_LOOP_SETPOINT_VALUE = 8'h0c;
    localparam logic [7:0] OFS_PERIPHERAL_ENABLE_ONE = 8'h10;
    localparam logic [7:0] OFS_DRIVE_STATUS = 8'h14;

    // Field positions
    localparam int BLANK_CODE_LSB = 0;
    localparam int SLOPE_RATE_LSB = 0;
    localparam int SLOPE_BYPASS_BIT = 6;
    localparam int SECONDARY_DELAY_LSB = 0;
    localparam int PRIMARY_DELAY_LSB = 4;
    localparam int PRIMARY_BYPASS_BIT = 0;
    localparam int SECONDARY_BYPASS_BIT = 1;

    // Values after reset
    localparam logic [1:0] BLANK_CODE_RST = 2'h0;
    localparam logic [5:0] SLOPE_RATE_RST = 6'h00;
    localparam logic SLOPE_BYPASS_RST = 1'b0;
    localparam logic [3:0] DELAY_CODE_RST = 4'h0;
    localparam logic [7:0] SETPOINT_RST = 8'h00;
    localparam logic TIMER_BYPASS_RST = 1'b0;

    // Analog scaling, informative for the analog side
    localparam int SLOPE_BASE_UV_PER_US = 4600;
    localparam int SLOPE_STEP_PERMILLE = 1080;
    localparam int DAC_STEP_UV = 4800;
    localparam int DAC_STEPS = 255;

    // Interval times and their cycle counts
    localparam int DEAD_STEP_NS = 16;
    localparam int BLANK_50_NS = 50;
    localparam int BLANK_100_NS = 100;
    localparam int BLANK_200_NS = 200;
    localparam int COUNT_W = 5;

    // Least times round up to whole cycles
    function automatic logic [COUNT_W-1:0] dbd_ns_to_cycles(input int ns);
        int cyc;
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (ns > 0 && cyc < 1) begin
            cyc = 1;
        end
        return COUNT_W'(cyc);
    endfunction

    function automatic logic [COUNT_W-1:0] dbd_blank_cycles(input logic [1:0] code);
        logic [COUNT_W-1:0] cyc;
        cyc = '0;
        unique case (code)
            2'h0: cyc = '0;
            2'h1: cyc = dbd_ns_to_cycles(BLANK_50_NS);
            2'h2: cyc = dbd_ns_to_cycles(BLANK_100_NS);
            2'h3: cyc = dbd_ns_to_cycles(BLANK_200_NS);
        endcase
        return cyc;
    endfunction

    function automatic logic [COUNT_W-1:0] dbd_dead_cycles(input logic [3:0] code);
        return dbd_ns_to_cycles(DEAD_STEP_NS * (int'(code) + 1));
    endfunction

endpackage

// File: dbd_delay.sv
module dbd_delay
    import dbd_pkg::*;
#(
    parameter int W = COUNT_W
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_start,
    input wire logic [W-1:0] i_count,
    output logic o_busy
);

    logic [W-1:0] remain;

    // A fresh start restarts the count even mid-interval
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            remain <= '0;
        end else if (i_clk_en) begin
            if (i_start && i_count != '0) begin
                remain <= i_count - W'(1);
            end else if (remain != '0) begin
                remain <= remain - W'(1);
            end
        end
    end

    // Busy for exactly i_count cycles, the start cycle included
    assign o_busy = (i_start && i_count != '0) || remain != '0;

endmodule // dbd_delay

// File: dbd_top.sv
// Summary of operation
// - Blanking code 00/01/10/11 gives no blanking, 50 ns, 100 ns or 200 ns after primary turn-on.
// - The six upper bits of the blanking register read zero and ignore writes.
// - Slope compensation is on while its bypass bit is zero and bypassed when it is one.
// - A six-bit slope rate code sets the ramp to 4.6 mV/us times 1.08 to the code.
// - Primary and secondary turn-on dead times are inserted independently.
// - Each dead timer works only while that drive's own bypass bit is clear.
// - An 8-bit setpoint value drives the reference DAC summed onto the pedestal.
// - The reference DAC steps about 4.8 mV per code over 255 steps.
// - Exactly four blanking settings, zero included, come from two register bits.
//
// Added by the designer: the address map and register access over AHB-Lite.
module dbd_top
    import dbd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_primary_request,
    input wire logic i_secondary_request,
    input wire logic i_current_sense_trip,
    output logic o_primary_gate_drive,
    output logic o_secondary_gate_drive,
    output logic o_current_trip,
    output logic o_slope_enable,
    output logic [5:0] o_slope_rate_code,
    output logic [7:0] o_loop_setpoint_value
);

    logic [1:0] blank_interval_code;
    logic slope_bypass;
    logic [5:0] slope_rate_code;
    logic [3:0] primary_delay_code;
    logic [3:0] secondary_delay_code;
    logic [7:0] loop_setpoint_value;
    logic primary_timer_bypass;
    logic secondary_timer_bypass;
    logic dphase_valid;
    logic dphase_write;
    logic [ADDR_W-1:0] dphase_addr;
    logic wr_en;
    logic sense_meta;
    logic sense_sync;
    logic prim_req_prev;
    logic sec_req_prev;
    logic prim_gate_prev;
    logic prim_busy;
    logic sec_busy;
    logic blank_busy;
    logic prim_start;
    logic sec_start;
    logic blank_start;
    logic [31:0] next_rdata;
    logic [7:0] status;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states unless the clock enable is low

    assign o_hreadyout = i_clk_en;
    assign o_hresp = 1'b0;

    // Only word transfers are expected, so the size is not decoded
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            dphase_valid <= 1'b0;
            dphase_write <= 1'b0;
            dphase_addr <= '0;
        end else if (i_clk_en && i_hready) begin
            dphase_valid <= i_hsel && i_htrans[1];
            dphase_write <= i_hwrite;
            dphase_addr <= i_haddr;
        end
    end

    assign wr_en = i_clk_en && dphase_valid && dphase_write;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            blank_interval_code <= BLANK_CODE_RST;
        end else if (wr_en && dphase_addr == ADDR_W'(OFS_BLANKING_SELECT)) begin
            blank_interval_code <= i_hwdata[BLANK_CODE_LSB +: 2];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            slope_bypass <= SLOPE_BYPASS_RST;
            slope_rate_code <= SLOPE_RATE_RST;
        end else if (wr_en && dphase_addr == ADDR_W'(OFS_SLOPE_RAMP_CONTROL)) begin
            slope_bypass <= i_hwdata[SLOPE_BYPASS_BIT];
            slope_rate_code <= i_hwdata[SLOPE_RATE_LSB +: 6];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            primary_delay_code <= DELAY_CODE_RST;
            secondary_delay_code <= DELAY_CODE_RST;
        end else if (wr_en && dphase_addr == ADDR_W'(OFS_DRIVE_DEAD_TIME)) begin
            primary_delay_code <= i_hwdata[PRIMARY_DELAY_LSB +: 4];
            secondary_delay_code <= i_hwdata[SECONDARY_DELAY_LSB +: 4];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            loop_setpoint_value <= SETPOINT_RST;
        end else if (wr_en && dphase_addr == ADDR_W'(OFS_LOOP_SETPOINT_VALUE)) begin
            loop_setpoint_value <= i_hwdata[7:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            primary_timer_bypass <= TIMER_BYPASS_RST;
            secondary_timer_bypass <= TIMER_BYPASS_RST;
        end else if (wr_en && dphase_addr == ADDR_W'(OFS_PERIPHERAL_ENABLE_ONE)) begin
            primary_timer_bypass <= i_hwdata[PRIMARY_BYPASS_BIT];
            secondary_timer_bypass <= i_hwdata[SECONDARY_BYPASS_BIT];
        end
    end

    assign status = {2'h0, sense_sync, blank_busy, sec_busy, prim_busy,
                     o_secondary_gate_drive, o_primary_gate_drive};

    // Unmapped offsets and unused bits read as zero
    always_comb begin
        next_rdata = '0;
        if (dphase_valid && !dphase_write) begin
            unique case (dphase_addr)
                ADDR_W'(OFS_BLANKING_SELECT): next_rdata[1:0] = blank_interval_code;
                ADDR_W'(OFS_SLOPE_RAMP_CONTROL): next_rdata[6:0] = {slope_bypass, slope_rate_code};
                ADDR_W'(OFS_DRIVE_DEAD_TIME):
                    next_rdata[7:0] = {primary_delay_code, secondary_delay_code};
                ADDR_W'(OFS_LOOP_SETPOINT_VALUE): next_rdata[7:0] = loop_setpoint_value;
                ADDR_W'(OFS_PERIPHERAL_ENABLE_ONE):
                    next_rdata[1:0] = {secondary_timer_bypass, primary_timer_bypass};
                ADDR_W'(OFS_DRIVE_STATUS): next_rdata[7:0] = status;
                default: next_rdata = '0;
            endcase
        end
    end

    // Read data is a mux of flip-flops so a write followed by a read sees the new value
    assign o_hrdata = next_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Dead-time insertion and leading edge blanking

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sense_meta <= 1'b0;
            sense_sync <= 1'b0;
        end else if (i_clk_en) begin
            sense_meta <= i_current_sense_trip;
            sense_sync <= sense_meta;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prim_req_prev <= 1'b0;
            sec_req_prev <= 1'b0;
            prim_gate_prev <= 1'b0;
        end else if (i_clk_en) begin
            prim_req_prev <= i_primary_request;
            sec_req_prev <= i_secondary_request;
            prim_gate_prev <= o_primary_gate_drive;
        end
    end

    assign prim_start = i_primary_request && !prim_req_prev && !primary_timer_bypass;
    assign sec_start = i_secondary_request && !sec_req_prev && !secondary_timer_bypass;
    assign blank_start = o_primary_gate_drive && !prim_gate_prev;

    dbd_delay u_prim_dead (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_start(prim_start),
        .i_count(dbd_dead_cycles(primary_delay_code)),
        .o_busy(prim_busy)
    );

    dbd_delay u_sec_dead (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_start(sec_start),
        .i_count(dbd_dead_cycles(secondary_delay_code)),
        .o_busy(sec_busy)
    );

    dbd_delay u_blank (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_start(blank_start),
        .i_count(dbd_blank_cycles(blank_interval_code)),
        .o_busy(blank_busy)
    );

    // Turn-off is never delayed; only the rising edge waits out its timer
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_primary_gate_drive <= 1'b0;
            o_secondary_gate_drive <= 1'b0;
        end else if (i_clk_en) begin
            o_primary_gate_drive <= i_primary_request && (primary_timer_bypass || !prim_busy);
            o_secondary_gate_drive <=
                i_secondary_request && (secondary_timer_bypass || !sec_busy);
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_current_trip <= 1'b0;
        end else if (i_clk_en) begin
            o_current_trip <= sense_sync && o_primary_gate_drive && !blank_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Analog settings; the ramp and DAC scaling live in the analog cells

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_slope_enable <= 1'b0;
            o_slope_rate_code <= SLOPE_RATE_RST;
            o_loop_setpoint_value <= SETPOINT_RST;
        end else if (i_clk_en) begin
            o_slope_enable <= !slope_bypass;
            o_slope_rate_code <= slope_rate_code;
            o_loop_setpoint_value <= loop_setpoint_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_blank_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (dphase_valid && !dphase_write && dphase_addr == ADDR_W'(OFS_BLANKING_SELECT))
        |-> o_hrdata[31:2] == '0)
        else $error("blanking register upper bits not zero");

    a_slope_bypass_out: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (wr_en && dphase_addr == ADDR_W'(OFS_SLOPE_RAMP_CONTROL) && i_hwdata[6]) ##1 i_clk_en
        |=> !o_slope_enable)
        else $error("slope stays enabled after bypass write");

    a_prim_dead_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_clk_en && prim_start) |=> !o_primary_gate_drive)
        else $error("primary drive rose without dead time");

    a_prim_bypass_pass: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_clk_en && primary_timer_bypass) |=> o_primary_gate_drive == $past(i_primary_request))
        else $error("bypassed primary drive not following request");

    a_sec_dead_indep: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_clk_en && sec_start && !prim_busy && i_primary_request)
        |=> !o_secondary_gate_drive && o_primary_gate_drive)
        else $error("secondary dead time not independent");

    a_blank_sense_mask: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_clk_en && blank_busy) |=> !o_current_trip)
        else $error("current trip passed during blanking");

    a_blank_none_code: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (blank_interval_code == 2'h0 && !$past(blank_busy)) |-> !blank_busy)
        else $error("blanking active with zero code");

    a_dac_setpoint_load: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (wr_en && dphase_addr == ADDR_W'(OFS_LOOP_SETPOINT_VALUE)) ##1 i_clk_en
        |=> o_loop_setpoint_value == $past(i_hwdata[7:0], 2))
        else $error("setpoint output not loaded from write");

endmodule // dbd_top

// File: dbd_fet_model.sv
module dbd_fet_model (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_gate,
    input wire logic [4:0] i_spike_len,
    input wire logic [4:0] i_trip_at,
    output logic o_sense_trip
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] on_cycles;

    // Cycles since the switch turned on; saturates so a long pulse never wraps
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            on_cycles <= 5'h00;
        end else if (!i_gate) begin
            on_cycles <= 5'h00;
        end else if (on_cycles != 5'h1f) begin
            on_cycles <= on_cycles + 5'h01;
        end
    end

    // Turn-on ringing first, then the current ramp crossing its limit; no current while off
    assign o_sense_trip = i_gate && (on_cycles < i_spike_len || on_cycles >= i_trip_at);
endmodule // dbd_fet_model

// File: drive_blanking_deadtime_cfg_bench.sv
module drive_blanking_deadtime_cfg_bench
    import dbd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] ofs; logic [31:0] wdata; logic [31:0] rdata;} dbd_row_t;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h00000000;
    logic preq = 1'b0;
    logic sreq = 1'b0;
    logic clk_en = 1'b1;
    logic [4:0] spike_len = 5'h00;
    logic [4:0] trip_at = 5'h00;
    logic [31:0] hrdata;
    logic hready, hresp, sense, pgate, sgate, trip, slope_en;
    logic [5:0] rate;
    logic [7:0] setpoint;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int blank_ns [4] = '{0, 50, 100, 200};
    logic [3:0] codes [3] = '{4'h0, 4'h5, 4'hf};
    // Status is read-only and idle here; last row is an unmapped offset
    dbd_row_t rows [7] = '{
        '{OFS_BLANKING_SELECT, 32'hffffffff, 32'h00000003},
        '{OFS_SLOPE_RAMP_CONTROL, 32'hffffffff, 32'h0000007f},
        '{OFS_DRIVE_DEAD_TIME, 32'h000000a5, 32'h000000a5},
        '{OFS_LOOP_SETPOINT_VALUE, 32'h000000c3, 32'h000000c3},
        '{OFS_PERIPHERAL_ENABLE_ONE, 32'h00000003, 32'h00000003},
        '{OFS_DRIVE_STATUS, 32'hffffffff, 32'h00000000},
        '{8'h1c, 32'hffffffff, 32'h00000000}
    };

    always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;

    // Size is tied: word transfers only
    dbd_top dut_u (
        .i_mclk(mclk), .i_resetn(resetn), .i_clk_en(clk_en), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_primary_request(preq), .i_secondary_request(sreq), .i_current_sense_trip(sense),
        .o_primary_gate_drive(pgate), .o_secondary_gate_drive(sgate), .o_current_trip(trip),
        .o_slope_enable(slope_en), .o_slope_rate_code(rate), .o_loop_setpoint_value(setpoint)
    );

    dbd_fet_model fet_u (
        .i_mclk(mclk), .i_resetn(resetn), .i_gate(pgate), .i_spike_len(spike_len),
        .i_trip_at(trip_at), .o_sense_trip(sense)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("[ERR] %0t run hung", $time);
            final_report();
        end
    end

    task automatic chk(input bit ok, input string what);
        total_checks++;
        if (!ok) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    // Entered right after a rising edge; returns at the edge that ends the data phase
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h00000000, x);
        chk(x === e && hresp === 1'b0, what);
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic reset_check();
        foreach (rows[i]) rd_chk(rows[i].ofs, 32'h00000000, "reset value");
        chk(slope_en === 1'b1 && rate === 6'h00 && setpoint === 8'h00, "config after reset");
        chk(pgate === 1'b0 && sgate === 1'b0 && trip === 1'b0, "drive after reset");
    endtask

    function automatic int cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // Both requests rise together; counts falling edges until each gate shows high
    task automatic gate_rise(output int kp, output int ks);
        kp = 0;
        ks = 0;
        @(posedge mclk);
        preq <= 1'b1;
        sreq <= 1'b1;
        for (int e = 1; e <= 20; e++) begin
            @(negedge mclk);
            if (kp == 0 && pgate === 1'b1) kp = e;
            if (ks == 0 && sgate === 1'b1) ks = e;
        end
        @(posedge mclk);
        preq <= 1'b0;
        sreq <= 1'b0;
        @(negedge mclk);
        chk(pgate === 1'b1 && sgate === 1'b1, "gate dropped early");
        @(negedge mclk);
        chk(pgate === 1'b0 && sgate === 1'b0, "gate late to fall");
        @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int kp, ks, m;
        logic seen;
        do_reset();
        reset_check();
        $display("reset values done");
        foreach (rows[i]) begin
            wr(rows[i].ofs, rows[i].wdata);
            rd_chk(rows[i].ofs, rows[i].rdata, "register readback");
        end
        chk(slope_en === 1'b0 && rate === 6'h3f && setpoint === 8'hc3, "config out");
        wr(OFS_SLOPE_RAMP_CONTROL, 32'h00000015);
        repeat (2) @(posedge mclk);
        chk(slope_en === 1'b1 && rate === 6'h15, "slope enable and rate");
        $display("register table done");

        wr(OFS_PERIPHERAL_ENABLE_ONE, 32'h00000000);
        foreach (codes[i]) begin
            wr(OFS_DRIVE_DEAD_TIME, {24'h000000, codes[i], 4'hf - codes[i]});
            gate_rise(kp, ks);
            chk(kp == cyc(DEAD_STEP_NS * (codes[i] + 1)) + 2, "primary dead time");
            chk(ks == cyc(DEAD_STEP_NS * (16 - codes[i])) + 2, "secondary dead time");
        end
        wr(OFS_PERIPHERAL_ENABLE_ONE, 32'h00000001);
        gate_rise(kp, ks);
        // Secondary code is still zero from the last table entry
        chk(kp == 2 && ks == cyc(DEAD_STEP_NS) + 2, "one timer bypassed");
        // A request shorter than the dead time must never reach the switch
        wr(OFS_PERIPHERAL_ENABLE_ONE, 32'h00000000);
        wr(OFS_DRIVE_DEAD_TIME, 32'h000000f0);
        preq <= 1'b1;
        rd_chk(OFS_DRIVE_STATUS, 32'h00000004, "status shows primary dead busy");
        repeat (3) @(posedge mclk);
        preq <= 1'b0;
        seen = 1'b0;
        repeat (15) @(negedge mclk) seen = seen | pgate;
        chk(seen === 1'b0, "short request drove gate");
        // Clock enable low freezes the timers and stalls the bus
        @(posedge mclk);
        clk_en <= 1'b0;
        preq <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(hready === 1'b0 && pgate === 1'b0 && sgate === 1'b0, "clock enable freeze");
        clk_en <= 1'b1;
        m = 0;
        while (pgate !== 1'b1 && m < 20) @(negedge mclk) m++;
        chk(m == cyc(DEAD_STEP_NS * 16) + 2, "dead time after freeze");
        @(posedge mclk);
        preq <= 1'b0;
        repeat (2) @(posedge mclk);
        $display("dead time done");

        wr(OFS_PERIPHERAL_ENABLE_ONE, 32'h00000001);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_BLANKING_SELECT, 32'(c));
            preq <= 1'b1;
            m = 0;
            while (pgate !== 1'b1 && m < 20) @(negedge mclk) m++;
            m = 0;
            while (trip !== 1'b1 && m < 30) @(negedge mclk) m++;
            kp = cyc(blank_ns[c]);
            chk(m >= kp + 1 && m <= kp + 4, "blanking length");
            @(posedge mclk);
            preq <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        // Turn-on ringing only: longest blanking hides it, no blanking lets it through
        spike_len <= 5'h04;
        trip_at <= 5'h1f;
        for (int j = 0; j < 2; j++) begin
            wr(OFS_BLANKING_SELECT, j == 0 ? 32'h00000003 : 32'h00000000);
            preq <= 1'b1;
            seen = 1'b0;
            repeat (15) @(negedge mclk) seen = seen | trip;
            chk(seen === (j == 1), "turn-on spike masking");
            @(posedge mclk);
            preq <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        $display("blanking done");

        do_reset();
        reset_check();
        $display("second reset done");
        final_report();
    end
endmodule // drive_blanking_deadtime_cfg_bench
